// ---- shared/wdt_sleep_pkg.sv ----
/*
 * Types of the watchdog and sleep controller: modes, states and carriers.
 * Assumes the constants of wdt_sleep_regs.svh for offsets and fields.
 */
package wdt_sleep_pkg;

    // two-bit enable configuration word
    typedef enum logic [1:0] {
        CFG_OFF = 2'b00,
        CFG_SW = 2'b01,
        CFG_AWAKE = 2'b10,
        CFG_ON = 2'b11
    } wdt_cfg_t;

    // power state machine, one-hot
    typedef enum logic [4:0] {
        ST_AWAKE = 5'b00001,
        ST_ASLEEP = 5'b00010,
        ST_OST_WAIT = 5'b00100,
        ST_RESUME = 5'b01000,
        ST_ISR_CALL = 5'b10000
    } pm_state_t;

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    // apb answer of the slave
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    // events from the cpu core and clock system
    typedef struct packed {
        logic clear_watchdog_instruction;
        logic sleep_instr;
        logic osc_fail;
        logic osc_startup_timer;
        logic crystal_mode;
        logic global_interrupt_enable;
    } core_evt_t;

    // controls back to the cpu core
    typedef struct packed {
        logic cpu_clk_en;
        logic fetch_next;
        logic resume;
        logic call_isr;
        logic wdt_reset;
    } core_ctl_t;

endpackage

// ---- shared/wdt_sleep_regs.svh ----
/*
 * Register offsets, field positions, reset values and timing counts of the
 * watchdog and sleep controller.
 * Assumes a 32-bit APB slave with byte addresses and one register per word.
 */
`ifndef WDT_SLEEP_REGS_SVH
`define WDT_SLEEP_REGS_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_IRQ_STAT 8'h08
`define OFS_IRQ_MASK 8'h0C
`define OFS_COUNT 8'h10

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CTRL_SWEN_BIT 0
`define CTRL_PS_LSB 1
`define CTRL_PS_MSB 5
`define STAT_TO_BIT 0
`define STAT_PD_BIT 1
`define STAT_SLEEP_BIT 2
`define STAT_ACTIVE_BIT 3
`define IRQ_WDT_WAKE 0
`define IRQ_INT_WAKE 1
`define IRQ_WDT_RESET 2
`define IRQ_SLEEP 3
`define IRQ_W 4

// ----------------------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------------------
`define PS_RESET 5'h0B
`define PS_MAX 5'h12

// ----------------------------------------------------------------------------
// timing: oscillator edges in one nominal watchdog tick
// ----------------------------------------------------------------------------
`define LFOSC_HZ 31000
`define TICK_PERIOD_MS 1
`define LF_EDGES_PER_TICK ((`LFOSC_HZ * `TICK_PERIOD_MS) / 1000)

`endif

// ---- src/lf_tick_gen.sv ----
/*
 * Nominal 1 ms tick from the 31 kHz low-frequency internal oscillator.
 * Assumes i_low_freq_internal_osc is a level synchronous to i_clk and much
 * slower than it, so each high phase spans several clock cycles.
 */
`timescale 1ns/10ps
`default_nettype none

module lf_tick_gen #(
    parameter int DIV = 31
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_low_freq_internal_osc,
    input wire logic i_clr,
    output logic o_tick
);

    localparam int CW = $clog2(DIV);

    typedef struct packed {
        logic osc_q;
        logic [CW-1:0] edges;
        logic tick;
    } tick_st_t;

    tick_st_t r;
    tick_st_t next_r;

    // --------------------------------------------------------------------
    // edge counting
    // --------------------------------------------------------------------
    // count oscillator rising edges, restart on clear
    always_comb begin
        next_r = r;
        next_r.osc_q = i_low_freq_internal_osc;
        next_r.tick = 1'b0;
        if (i_clr) begin
            next_r.edges = '0;
        end else if (i_low_freq_internal_osc && !r.osc_q) begin
            if (r.edges == CW'(DIV - 1)) begin
                next_r.edges = '0;
                next_r.tick = 1'b1;
            end else begin
                next_r.edges = r.edges + CW'(1);
            end
        end
    end

    // state register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign o_tick = r.tick;

endmodule

`default_nettype wire

// ---- src/wdt_sleep_ctrl.sv ----
/*
 * Watchdog timer with power-down entry and wake-up control, APB registers
 * and a maskable interrupt for its events.
 * Assumes the core pulses its instruction events for one cycle, that device
 * resets arrive on i_rst_n, and that all inputs are synchronous to i_clk.
 */
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

`include "wdt_sleep_regs.svh"

// Function
// [R1] count only 1 ms ticks from oscillator
// [R2] config 11: active always, sleep too
// [R3] config 10: active awake, off asleep
// [R4] config 01: software enable bit decides
// [R5] config 00: always disabled
// [R6] prescale select sets 1 ms to 256 s
// [R7] prescale resets to 2 s period
// [R8] clear on reset, instruction, sleep, wake, faults
// [R9] oscillator divider change leaves count alone
// [R10] crystal wake holds count clear until startup
// [R11] sleep time-out wakes, updates status flags
// [R12] awake time-out requests device reset
// [R13] sleep clears power-down, sets time-out, stops cpu
// [R14] ports hold their drive during sleep
// [R15] reset sources reset; others resume execution
// [R16] sleep instruction prefetches next instruction
// [R17] enabled source wakes regardless of global enable
// [R18] run prefetched, then isr if enabled
module wdt_sleep_ctrl import wdt_sleep_pkg::*; #(
    parameter int PORT_W = 8,
    parameter int IRQ_SRC = 8,
    parameter int CNT_W = 19,
    parameter int LF_DIV = `LF_EDGES_PER_TICK
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire apb_req_t i_apb,
    output apb_rsp_t o_apb,
    input wire logic [1:0] i_watchdog_enable_config,
    input wire logic i_low_freq_internal_osc,
    input wire core_evt_t i_core,
    output core_ctl_t o_core,
    input wire logic [IRQ_SRC-1:0] i_int_flags,
    input wire logic [IRQ_SRC-1:0] i_int_enables,
    input wire logic [PORT_W-1:0] i_port_out,
    input wire logic [PORT_W-1:0] i_port_oe_n,
    output logic [PORT_W-1:0] o_port_out,
    output logic [PORT_W-1:0] o_port_oe_n,
    output logic o_timeout_flag,
    output logic o_power_down_flag,
    output logic o_irq
);

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    typedef struct packed {
        pm_state_t state;
        logic [CNT_W-1:0] count;
        logic software_watchdog_enable;
        logic [4:0] timeout_prescale_select;
        logic timeout_flag;
        logic power_down_flag;
        logic wake_int;
        logic [`IRQ_W-1:0] irq_stat;
        logic [`IRQ_W-1:0] irq_mask;
        logic irq;
        apb_rsp_t apb;
        core_ctl_t ctl;
        logic [PORT_W-1:0] port_out;
        logic [PORT_W-1:0] port_oe_n;
    } st_t;

    localparam st_t RST_VAL = '{
        state: ST_AWAKE,
        count: '0,
        software_watchdog_enable: 1'b0,
        timeout_prescale_select: `PS_RESET,
        timeout_flag: 1'b1,
        power_down_flag: 1'b1,
        wake_int: 1'b0,
        irq_stat: '0,
        irq_mask: '0,
        irq: 1'b0,
        apb: '0,
        ctl: '{cpu_clk_en: 1'b1, default: 1'b0},
        port_out: '0,
        port_oe_n: '1
    };

    st_t r;
    st_t next_r;
    logic tick;
    logic clr;

    // ------------------------------------------------------------------------
    // millisecond time base
    // ------------------------------------------------------------------------
    // [R1] oscillator-derived tick only
    lf_tick_gen #(
        .DIV(LF_DIV)
    ) u_tick (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_low_freq_internal_osc(i_low_freq_internal_osc),
        .i_clr(clr),
        .o_tick(tick)
    );

    // ------------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------------
    // watchdog, power states, flags and register access
    always_comb begin
        logic asleep;
        logic active;
        logic [4:0] ps_eff;
        logic [CNT_W-1:0] limit;
        logic timeout;
        logic sleep_entry;
        logic wake;
        logic int_req;
        logic access;
        logic commit;
        logic [`IRQ_W-1:0] evt;
        logic [`IRQ_W-1:0] w1c;
        asleep = (r.state == ST_ASLEEP) || (r.state == ST_OST_WAIT);
        active = 1'b0;
        ps_eff = '0;
        limit = '0;
        timeout = 1'b0;
        sleep_entry = 1'b0;
        wake = 1'b0;
        int_req = 1'b0;
        access = i_apb.psel && i_apb.penable;
        commit = access && r.apb.pready;
        evt = '0;
        w1c = '0;
        next_r = r;
        next_r.ctl.fetch_next = 1'b0;
        next_r.ctl.resume = 1'b0;
        next_r.ctl.call_isr = 1'b0;
        next_r.ctl.wdt_reset = 1'b0;

        // enable mode from the configuration word
        unique case (wdt_cfg_t'(i_watchdog_enable_config))
            // [R2] always on
            CFG_ON: active = 1'b1;
            // [R3] off in sleep
            CFG_AWAKE: active = !asleep;
            // [R4] software enable bit
            CFG_SW: active = r.software_watchdog_enable;
            // [R5] always disabled
            CFG_OFF: active = 1'b0;
        endcase

        // [R6] period is 2^select milliseconds, select above 18 treated as 18
        ps_eff = (r.timeout_prescale_select > `PS_MAX) ? `PS_MAX : r.timeout_prescale_select;
        limit = (CNT_W'(1) << ps_eff) - CNT_W'(1);
        timeout = active && tick && (r.count == limit);
        int_req = |(i_int_flags & i_int_enables);

        // power state sequencing
        unique case (r.state)
            ST_AWAKE: begin
                if (timeout) begin
                    // [R12] reset request when awake
                    next_r.ctl.wdt_reset = 1'b1;
                    next_r.timeout_flag = 1'b0;
                    evt[`IRQ_WDT_RESET] = 1'b1;
                end else if (i_core.sleep_instr) begin
                    // [R13] enter power-down
                    sleep_entry = 1'b1;
                    next_r.state = ST_ASLEEP;
                    next_r.power_down_flag = 1'b0;
                    next_r.timeout_flag = 1'b1;
                    next_r.ctl.cpu_clk_en = 1'b0;
                    // [R16] prefetch following instruction
                    next_r.ctl.fetch_next = 1'b1;
                    evt[`IRQ_SLEEP] = 1'b1;
                end
            end
            ST_ASLEEP: begin
                if (timeout) begin
                    // [R11] wake instead of reset
                    wake = 1'b1;
                    next_r.timeout_flag = 1'b0;
                    next_r.wake_int = 1'b0;
                    evt[`IRQ_WDT_WAKE] = 1'b1;
                end else if (int_req) begin
                    // [R17] own enable, global ignored
                    wake = 1'b1;
                    next_r.wake_int = 1'b1;
                    evt[`IRQ_INT_WAKE] = 1'b1;
                end
                if (wake) begin
                    // [R10] crystal waits for startup timer
                    if (i_core.crystal_mode) begin
                        next_r.state = ST_OST_WAIT;
                    end else begin
                        next_r.state = ST_RESUME;
                        next_r.ctl.cpu_clk_en = 1'b1;
                        next_r.ctl.resume = 1'b1;
                    end
                end
            end
            ST_OST_WAIT: begin
                if (!i_core.osc_startup_timer) begin
                    next_r.state = ST_RESUME;
                    next_r.ctl.cpu_clk_en = 1'b1;
                    next_r.ctl.resume = 1'b1;
                end
            end
            ST_RESUME: begin
                // [R18] prefetched runs, then isr call
                if (r.wake_int && i_core.global_interrupt_enable) begin
                    next_r.state = ST_ISR_CALL;
                    next_r.ctl.call_isr = 1'b1;
                end else begin
                    next_r.state = ST_AWAKE;
                end
            end
            ST_ISR_CALL: begin
                next_r.state = ST_AWAKE;
            end
        endcase

        // [R8] clearing conditions of the count
        clr = i_core.clear_watchdog_instruction || sleep_entry || wake || i_core.osc_fail
            || !active || i_core.osc_startup_timer || (r.state == ST_OST_WAIT);
        // [R9] divider changes are not a clear
        if (clr || timeout) begin
            next_r.count = '0;
        end else if (tick) begin
            next_r.count = r.count + CNT_W'(1);
        end

        // [R14] ports follow the core only while awake
        if (r.state == ST_AWAKE) begin
            next_r.port_out = i_port_out;
            next_r.port_oe_n = i_port_oe_n;
        end

        // apb read data in the first access cycle
        next_r.apb.pready = access && !r.apb.pready;
        next_r.apb.pslverr = 1'b0;
        next_r.apb.prdata = '0;
        if (access && !r.apb.pready) begin
            unique case (i_apb.paddr)
                `OFS_CTRL: begin
                    next_r.apb.prdata[`CTRL_SWEN_BIT] = r.software_watchdog_enable;
                    next_r.apb.prdata[`CTRL_PS_MSB:`CTRL_PS_LSB] = r.timeout_prescale_select;
                end
                `OFS_STATUS: begin
                    next_r.apb.prdata[`STAT_TO_BIT] = r.timeout_flag;
                    next_r.apb.prdata[`STAT_PD_BIT] = r.power_down_flag;
                    next_r.apb.prdata[`STAT_SLEEP_BIT] = asleep;
                    next_r.apb.prdata[`STAT_ACTIVE_BIT] = active;
                end
                `OFS_IRQ_STAT: next_r.apb.prdata[`IRQ_W-1:0] = r.irq_stat;
                `OFS_IRQ_MASK: next_r.apb.prdata[`IRQ_W-1:0] = r.irq_mask;
                `OFS_COUNT: next_r.apb.prdata[CNT_W-1:0] = r.count;
                default: next_r.apb.pslverr = 1'b1;
            endcase
        end

        // apb writes take effect at the completing edge
        if (commit && i_apb.pwrite) begin
            unique case (i_apb.paddr)
                `OFS_CTRL: begin
                    next_r.software_watchdog_enable = i_apb.pwdata[`CTRL_SWEN_BIT];
                    next_r.timeout_prescale_select = i_apb.pwdata[`CTRL_PS_MSB:`CTRL_PS_LSB];
                end
                `OFS_IRQ_STAT: w1c = i_apb.pwdata[`IRQ_W-1:0];
                `OFS_IRQ_MASK: next_r.irq_mask = i_apb.pwdata[`IRQ_W-1:0];
                default: w1c = '0;
            endcase
        end

        // sticky events, a set beats a clear
        next_r.irq_stat = (r.irq_stat & ~w1c) | evt;
        next_r.irq = |(next_r.irq_stat & next_r.irq_mask);
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    // [R8] any reset clears count, [R7] prescale default
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r <= RST_VAL;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------------------
    // outputs, all from flip-flops
    // ------------------------------------------------------------------------
    // [R15] resume pulses for wake, reset only externally
    assign o_apb = r.apb;
    assign o_core = r.ctl;
    assign o_port_out = r.port_out;
    assign o_port_oe_n = r.port_oe_n;
    assign o_timeout_flag = r.timeout_flag;
    assign o_power_down_flag = r.power_down_flag;
    assign o_irq = r.irq;

endmodule

`default_nettype wire

// ---- test/watchdog_with_sleep_wake_control_test.sv ----
/* self-checking bench of the watchdog and sleep controller.
   assumes the design package and register header on the include path. */
`timescale 1ns/10ps
`default_nettype none
`include "wdt_sleep_regs.svh"

module watchdog_with_sleep_wake_control_test import wdt_sleep_pkg::*;;
    // ------------------------------------------------------------------
    // stimulus and design
    // ------------------------------------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic osc = 1'b0;
    logic [1:0] cfg = 2'b00;
    apb_req_t apb = '0;
    apb_rsp_t rsp;
    core_evt_t ev = '0;
    core_ctl_t ctl;
    logic [7:0] iflg = '0, ien = '0, pout = '0, poe = '1, oout, ooe;
    logic to_f, pd_f, irq, e;
    logic [31:0] r;
    int bad_count = 0, total_checks = 0, n_rst = 0, n_res = 0, n_isr = 0, ocnt = 0;

    always #12.5 clk = !clk;

    always @(posedge clk) begin
        ocnt <= (ocnt == 2) ? 0 : ocnt + 1;
        if (ocnt == 2) osc <= !osc;
    end

    // count core pulses
    always @(posedge clk) begin
        if (ctl.wdt_reset === 1'b1) n_rst++;
        if (ctl.resume === 1'b1) n_res++;
        if (ctl.call_isr === 1'b1) n_isr++;
    end

    wdt_sleep_ctrl #(.LF_DIV(2)) i_dut (
        .i_clk(clk), .i_rst_n(rst_n), .i_apb(apb), .o_apb(rsp), .i_watchdog_enable_config(cfg),
        .i_low_freq_internal_osc(osc), .i_core(ev), .o_core(ctl), .i_int_flags(iflg), .i_int_enables(ien),
        .i_port_out(pout), .i_port_oe_n(poe), .o_port_out(oout), .o_port_oe_n(ooe),
        .o_timeout_flag(to_f), .o_power_down_flag(pd_f), .o_irq(irq)
    );

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // one apb transfer, held until pready
    task automatic apb_x(input logic [7:0] a, input logic w, input logic [31:0] d);
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        apb.penable <= 1'b1;
        // wait for the answer, only the watchdog process ends a hang
        do begin
            @(posedge clk);
        end while (rsp.pready !== 1'b1);
        r = rsp.prdata;
        e = rsp.pslverr;
        apb <= '0;
        // idle edge so the next call never reassigns in this time step
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb_x(a, 1'b0, 32'h0);
        chk(r, x);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb_x(a, 1'b1, d);
    endtask

    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        rd(`OFS_CTRL, 32'h16);
        rd(`OFS_STATUS, 32'h3);
        rd(`OFS_COUNT, 32'h0);
        rd(`OFS_IRQ_STAT, 32'h0);
        rd(8'h14, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk({29'h0, to_f, pd_f, irq}, 32'h6);
    endtask

    // entries: config, software enable, expected activity
    task automatic t_modes;
        logic [3:0] tbl [5] = '{4'b1101, 4'b1001, 4'b0111, 4'b0100, 4'b0010};
        foreach (tbl[i]) begin
            wr(`OFS_CTRL, {26'h0, 5'h0B, tbl[i][1]});
            cfg <= tbl[i][3:2];
            repeat (40) @(posedge clk);
            rd(`OFS_STATUS, {28'h0, tbl[i][0], 3'b011});
            apb_x(`OFS_COUNT, 1'b0, 32'h0);
            chk({31'h0, r == 32'h0}, {31'h0, !tbl[i][0]});
        end
        cfg <= 2'b00;
    endtask

    task automatic t_awake;
        int n;
        cfg <= 2'b01;
        wr(`OFS_CTRL, 32'h5);
        wr(`OFS_IRQ_MASK, 32'h4);
        n_rst = 0;
        repeat (6) begin
            repeat (30) @(posedge clk);
            ev.clear_watchdog_instruction <= 1'b1;
            @(posedge clk);
            ev.clear_watchdog_instruction <= 1'b0;
        end
        // oscillator fail holds the count clear past a full period
        ev.osc_fail <= 1'b1;
        repeat (60) @(posedge clk);
        ev.osc_fail <= 1'b0;
        chk(n_rst, 0);
        n = 0;
        while (n_rst == 0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        cfg <= 2'b00;
        chk({31'h0, n >= 38 && n <= 56}, 32'h1);
        @(posedge clk);
        chk({30'h0, to_f, pd_f}, 32'h1);
        rd(`OFS_IRQ_STAT, 32'h4);
        chk({31'h0, irq}, 32'h1);
        wr(`OFS_IRQ_MASK, 32'h0);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        wr(`OFS_IRQ_STAT, 32'h4);
        rd(`OFS_IRQ_STAT, 32'h0);
        do_reset;
        chk({30'h0, to_f, pd_f}, 32'h3);
    endtask

    task automatic t_sleep(input logic [1:0] c, input logic g, input logic x, input logic w);
        int n;
        wr(`OFS_CTRL, 32'h0);
        ev.global_interrupt_enable <= g;
        ev.crystal_mode <= x;
        ev.osc_startup_timer <= x;
        pout <= 8'hA5;
        poe <= 8'h0F;
        repeat (2) @(posedge clk);
        cfg <= c;
        ev.sleep_instr <= 1'b1;
        n_res = 0;
        n_isr = 0;
        @(posedge clk);
        ev.sleep_instr <= 1'b0;
        @(posedge clk);
        chk({28'h0, ctl.fetch_next, ctl.cpu_clk_en, pd_f, to_f}, 32'h9);
        pout <= 8'h5A;
        poe <= 8'hF0;
        n = 0;
        while (n_res == 0 && n < 60) begin
            @(posedge clk);
            n++;
        end
        cfg <= 2'b00;
        chk(n_res, {31'h0, w});
        if (w) begin
            repeat (3) @(posedge clk);
            chk({n_isr[29:0], to_f, pd_f}, 32'h0);
        end else begin
            chk({16'h0, oout, ooe}, 32'hA50F);
            iflg <= 8'h10;
            repeat (10) @(posedge clk);
            chk(n_res, 0);
            ien <= 8'h10;
            repeat (10) @(posedge clk);
            chk(n_res, {31'h0, !x});
            ev.osc_startup_timer <= 1'b0;
            repeat (10) @(posedge clk);
            chk({n_res[15:0], n_isr[15:0]}, {16'h1, 15'h0, g});
            iflg <= 8'h0;
            ien <= 8'h0;
        end
        rd(`OFS_IRQ_STAT, w ? 32'h9 : 32'hA);
        wr(`OFS_IRQ_STAT, 32'hF);
    endtask

    // ------------------------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------------------------
    initial begin
        do_reset;
        t_reset;
        t_modes;
        t_awake;
        t_sleep(2'b00, 1'b0, 1'b0, 1'b0);
        t_sleep(2'b00, 1'b1, 1'b0, 1'b0);
        t_sleep(2'b00, 1'b1, 1'b1, 1'b0);
        t_sleep(2'b10, 1'b0, 1'b0, 1'b0);
        t_sleep(2'b11, 1'b1, 1'b0, 1'b1);
        end_sim;
    end

    initial begin
        #500000;
        bad_count++;
        end_sim;
    end
endmodule

`default_nettype wire

// ---- test/wdt_sleep_props.sv ----
/* concurrent checks on the watchdog and sleep controller ports.
   assumes one clock domain and binding into wdt_sleep_ctrl. */
`timescale 1ns/10ps
`default_nettype none

module wdt_sleep_props import wdt_sleep_pkg::*; #(
    parameter int PORT_W = 8,
    parameter int IRQ_SRC = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire apb_req_t i_apb,
    input wire apb_rsp_t o_apb,
    input wire logic [1:0] i_watchdog_enable_config,
    input wire core_evt_t i_core,
    input wire core_ctl_t o_core,
    input wire logic [IRQ_SRC-1:0] i_int_flags,
    input wire logic [IRQ_SRC-1:0] i_int_enables,
    input wire logic [PORT_W-1:0] o_port_out,
    input wire logic [PORT_W-1:0] o_port_oe_n,
    input wire logic o_timeout_flag,
    input wire logic o_power_down_flag
);
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_sleep_entry_flags: assert property (o_core.fetch_next |->
        !o_core.cpu_clk_en && !o_power_down_flag && o_timeout_flag) else $error("sleep entry state wrong");
    a_prefetch_cause: assert property (o_core.fetch_next |-> $past(i_core.sleep_instr))
        else $error("prefetch without sleep");
    a_port_hold: assert property (!o_core.cpu_clk_en && !$past(o_core.cpu_clk_en) |->
        $stable(o_port_out) && $stable(o_port_oe_n)) else $error("port drive moved in sleep");
    a_awake_reset: assert property (o_core.wdt_reset |-> o_core.cpu_clk_en && !o_timeout_flag)
        else $error("reset request outside awake time-out");
    a_off_quiet: assert property (i_watchdog_enable_config == 2'b00 ##1
        i_watchdog_enable_config == 2'b00 |=> !o_core.wdt_reset) else $error("time-out while off");
    a_int_wake: assert property (!o_core.cpu_clk_en && !i_core.crystal_mode &&
        |(i_int_flags & i_int_enables) |-> ##[1:2] o_core.resume) else $error("enabled source did not wake");
    a_isr_gie: assert property (o_core.call_isr |->
        $past(o_core.resume) && $past(i_core.global_interrupt_enable)) else $error("isr call out of order");
    a_apb_wait: assert property (i_apb.psel && i_apb.penable && !o_apb.pready |=> o_apb.pready)
        else $error("apb answer late");
    a_apb_unmapped: assert property (o_apb.pready && i_apb.paddr > 8'h10 |->
        o_apb.pslverr && o_apb.prdata == 32'h0) else $error("unmapped access accepted");

    c_sleep: cover property (o_core.fetch_next);
    c_wdt_reset: cover property (o_core.wdt_reset);
    c_isr: cover property (o_core.call_isr);
endmodule

bind wdt_sleep_ctrl wdt_sleep_props #(.PORT_W(PORT_W), .IRQ_SRC(IRQ_SRC)) u_props (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_apb(i_apb), .o_apb(o_apb),
    .i_watchdog_enable_config(i_watchdog_enable_config), .i_core(i_core), .o_core(o_core),
    .i_int_flags(i_int_flags), .i_int_enables(i_int_enables), .o_port_out(o_port_out),
    .o_port_oe_n(o_port_oe_n), .o_timeout_flag(o_timeout_flag), .o_power_down_flag(o_power_down_flag)
);

`default_nettype wire
